// [hw/rpm_pkg.sv]
// package: constants and types for the reset and power mode controller
package rpm_pkg;

  // ----------------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONFIG = 8'h00; // power_config_register
  localparam logic [7:0] ADDR_AUX_CONTROL  = 8'h04; // auxiliary_control_one
  localparam logic [7:0] ADDR_STATUS       = 8'h08; // sequencer status, read only

  // power_config_register field positions
  localparam int POS_IDLE  = 0;  // idle_request_bit
  localparam int POS_PDOWN = 1;  // powerdown_request_bit
  localparam int POS_GF0   = 2;  // general_flag_zero
  localparam int POS_GF1   = 3;  // general_flag_one
  localparam int POS_ADCI  = 4;  // idle entered through the converter option

  // auxiliary_control_one field positions
  localparam int POS_BOOT  = 0;  // boot_map_enable
  localparam int POS_X2    = 1;  // clock_doubling_mode

  // status field positions
  localparam int POS_ST_RESET = 0; // internal reset active
  localparam int POS_ST_CPUCK = 1; // cpu clock enabled
  localparam int POS_ST_OSC   = 2; // oscillator running
  localparam int POS_ST_HOLD  = 3; // wake held by level interrupt
  localparam int POS_ST_WDRST = 4; // supervisor pulse active

  localparam logic [31:0] RESET_VALUE = 32'h0000_0000; // reset value of the power config and auxiliary fields

  // ----------------------------------------------------------------------
  // timing counts, in oscillator periods
  // ----------------------------------------------------------------------
  localparam int          QUAL_PERIODS = 24;  // least reset hold, mode independent
  localparam int          WD_PERIODS   = 96;  // supervisor reset pulse length
  localparam logic [6:0]  QUAL_COUNT   = 7'(QUAL_PERIODS);
  localparam logic [6:0]  WD_COUNT     = 7'(WD_PERIODS);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RPM_RUN,
    RPM_IDLE,
    RPM_PDOWN,
    RPM_WAKE_HOLD
  } rpm_mode_t;

  typedef struct packed {
    logic idle;   // idle_request_bit
    logic pdown;  // powerdown_request_bit
    logic gf0;    // general_flag_zero
    logic gf1;    // general_flag_one
    logic adci;   // converter idle option
  } rpm_power_config_register_t;

endpackage

// [hw/rpm_ctrl.sv]
// module: reset qualification and idle / power-down sequencing
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rpm_ctrl
  import rpm_pkg::*;
(
  input  wire logic        CLK_IN,            // oscillator clock, 125 MHz
  input  wire logic        RST_B_IN,          // synchronous reset, active low
  // apb slave
  input  wire logic        PSEL_IN,           // apb select
  input  wire logic        PENABLE_IN,        // apb access phase
  input  wire logic        PWRITE_IN,         // apb direction
  input  wire logic [7:0]  PADDR_IN,          // apb byte address
  input  wire logic [31:0] PWDATA_IN,         // apb write data
  output logic      [31:0] PRDATA_OUT,        // apb read data
  output logic             PREADY_OUT,        // apb ready
  output logic             PSLVERR_OUT,       // apb error, unmapped address
  // reset pin and sources
  input  wire logic        RESET_PIN_IN,      // reset pin level, active high
  output logic             RESET_PIN_OUT,     // pin drive value, high when driving
  output logic             RESET_PIN_OE_B_OUT,// pin enable, low while driving
  input  wire logic        WD_EXPIRE_IN,      // supervisor_timer expiry pulse
  input  wire logic        BOOT_FUSE_IN,      // boot_jump_fuse value
  // wake sources
  input  wire logic        INT_PENDING_IN,    // enabled interrupt pending
  input  wire logic        EXT_INT_IN,        // enabled external interrupt pending
  input  wire logic        EXT_INT_LEVEL_IN,  // level of that interrupt line, active high
  input  wire logic        ADC_DONE_IN,       // conversion complete pulse
  // outputs to the core
  output logic             CPU_RESET_OUT,     // internal reset, active high
  output logic             CPU_CLK_EN_OUT,    // cpu clock enable
  output logic             PERIPH_CLK_EN_OUT, // peripheral clock enable
  output logic             OSC_RUN_OUT,       // oscillator enable
  output logic             RAM_BLOCK_OUT,     // internal ram access blocked
  output logic             BOOT_MAP_OUT,      // boot_map_enable
  output logic             CLK_DOUBLE_OUT     // clock_doubling_mode
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rpm_mode_t   mode;            // current power mode
  rpm_mode_t   next_mode;       // mode after this edge
  rpm_power_config_register_t   power_config_register;            // power_config_register fields
  rpm_power_config_register_t   next_power_config_register;       // next power config value
  logic        boot_map;        // boot_map_enable
  logic        clk_double;      // clock_doubling_mode
  logic        rst_meta;        // reset pin first stage
  logic        rst_sync;        // reset pin second stage
  logic [6:0]  qual_cnt;        // consecutive high periods of the pin
  logic        int_reset;       // qualified internal reset
  logic [6:0]  wd_cnt;          // supervisor pulse remaining
  logic        ram_block;       // brief run after a pin wake

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire access    = PSEL_IN && PENABLE_IN;         // access phase, slave always ready
  wire hit_power_config_register  = (PADDR_IN == ADDR_POWER_CONFIG);
  wire hit_aux   = (PADDR_IN == ADDR_AUX_CONTROL);
  wire hit_stat  = (PADDR_IN == ADDR_STATUS);
  wire mapped    = hit_power_config_register || hit_aux || hit_stat;
  wire wr_power_config_register   = access && PWRITE_IN && hit_power_config_register;
  wire wr_aux    = access && PWRITE_IN && hit_aux;

  // request bits written by this very access; entry follows the write at once
  wire req_idle  = wr_power_config_register && PWDATA_IN[POS_IDLE];
  wire req_pdown = wr_power_config_register && PWDATA_IN[POS_PDOWN];

  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = access && !mapped;

  wire [31:0] power_config_register_rd = {27'h0, power_config_register.adci, power_config_register.gf1, power_config_register.gf0, power_config_register.pdown, power_config_register.idle};
  wire [31:0] aux_rd  = {30'h0, clk_double, boot_map};
  wire [31:0] stat_rd = {27'h0, (wd_cnt != 7'h00), (mode == RPM_WAKE_HOLD),
                         OSC_RUN_OUT, CPU_CLK_EN_OUT, int_reset};
  wire [31:0] rd_mux  = hit_power_config_register ? power_config_register_rd : hit_aux ? aux_rd : hit_stat ? stat_rd : 32'h0;

  // read data registered in the setup phase so it is a flop at the access edge
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      PRDATA_OUT <= RESET_VALUE;
    else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
      PRDATA_OUT <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // reset pin synchroniser and qualification
  // ----------------------------------------------------------------------
  // first stage feeds only the second
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= RESET_PIN_IN;
      rst_sync <= rst_meta;
    end
  end

  // counts oscillator periods, never machine cycles, so x2 has no effect
  wire qual_done = (qual_cnt >= QUAL_COUNT - 7'd1);

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      qual_cnt <= 7'h00;
    else if (!rst_sync)
      qual_cnt <= 7'h00;
    else if (!qual_done)
      qual_cnt <= qual_cnt + 7'd1;
  end

  // a shorter pulse from the pin is not a valid reset and is dropped
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      int_reset <= 1'b1;
    else
      int_reset <= rst_sync && qual_done;
  end

  // ----------------------------------------------------------------------
  // supervisor pulse onto the reset pin
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      wd_cnt <= 7'h00;
    else if (WD_EXPIRE_IN)
      wd_cnt <= WD_COUNT;
    else if (wd_cnt != 7'h00)
      wd_cnt <= wd_cnt - 7'd1;
  end

  // the pin is active high, so the pulse drives it high for 96 periods
  assign RESET_PIN_OUT      = 1'b1;
  assign RESET_PIN_OE_B_OUT = (wd_cnt == 7'h00);

  // ----------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------
  // the raw pin level clears the request bits without waiting for an edge;
  // the raw pin is used here on purpose and bypasses the synchroniser
  wire pin_clear = RESET_PIN_IN;

  always_comb
  begin
    next_mode = mode;
    next_power_config_register = power_config_register;
    if (wr_power_config_register)
    begin
      next_power_config_register.gf0  = PWDATA_IN[POS_GF0];
      next_power_config_register.gf1  = PWDATA_IN[POS_GF1];
      next_power_config_register.adci = PWDATA_IN[POS_ADCI];
    end
    case (mode)
      RPM_RUN:
      begin
        if (req_pdown)
        begin
          next_mode       = RPM_PDOWN;
          next_power_config_register.pdown = 1'b1;
          next_power_config_register.idle  = 1'b0;
        end
        else if (req_idle)
        begin
          next_mode      = RPM_IDLE;
          next_power_config_register.idle = 1'b1;
        end
      end
      RPM_IDLE:
      begin
        // any idle leaves on interrupt, converter idle also on conversion done
        if (INT_PENDING_IN || (power_config_register.adci && ADC_DONE_IN))
        begin
          next_mode      = RPM_RUN;
          next_power_config_register.idle = 1'b0;
        end
      end
      RPM_PDOWN:
      begin
        if (EXT_INT_IN)
        begin
          next_power_config_register.pdown = 1'b0;
          next_mode = EXT_INT_LEVEL_IN ? RPM_WAKE_HOLD : RPM_RUN;
        end
      end
      RPM_WAKE_HOLD:
      begin
        // clocks run again but the cpu waits for the line to release
        if (!EXT_INT_LEVEL_IN)
          next_mode = RPM_RUN;
      end
      default:
        next_mode = RPM_RUN;
    endcase
    if (pin_clear)
    begin
      next_power_config_register.idle  = 1'b0;
      next_power_config_register.pdown = 1'b0;
      next_mode       = RPM_RUN;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      mode <= RPM_RUN;
      power_config_register <= rpm_power_config_register_t'(5'h00);
    end
    else if (int_reset)
    begin
      mode <= RPM_RUN;
      power_config_register <= rpm_power_config_register_t'(5'h00);
    end
    else
    begin
      mode <= next_mode;
      power_config_register <= next_power_config_register;
    end
  end

  // ----------------------------------------------------------------------
  // brief run after a pin wake: ram blocked until internal reset
  // ----------------------------------------------------------------------
  wire low_power = (mode == RPM_IDLE) || (mode == RPM_PDOWN);

  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
      ram_block <= 1'b0;
    else if (int_reset)
      ram_block <= 1'b0;
    else if (low_power && pin_clear)
      ram_block <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // auxiliary control: boot map and clock mode
  // ----------------------------------------------------------------------
  // boot map is reloaded from the fuse only while the qualified internal reset is active, so a
  // short pin pulse that fails qualification leaves the boot map as it was
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      boot_map   <= 1'b0;
      clk_double <= 1'b0;
    end
    else if (int_reset)
    begin
      boot_map   <= BOOT_FUSE_IN;
      clk_double <= 1'b0;
    end
    else if (wr_aux)
    begin
      boot_map   <= PWDATA_IN[POS_BOOT];
      clk_double <= PWDATA_IN[POS_X2];
    end
  end

  // ----------------------------------------------------------------------
  // clock gating outputs
  // ----------------------------------------------------------------------
  // stopping the enables freezes pc, psw, sfrs and ram in place
  wire pd_now   = (mode == RPM_PDOWN) && !pin_clear;
  wire idle_now = (mode == RPM_IDLE) && !pin_clear;

  assign CPU_CLK_EN_OUT    = !idle_now && !pd_now && (mode != RPM_WAKE_HOLD);
  assign PERIPH_CLK_EN_OUT = !pd_now;
  assign OSC_RUN_OUT       = !pd_now;
  assign RAM_BLOCK_OUT     = ram_block;
  assign CPU_RESET_OUT     = int_reset;
  assign BOOT_MAP_OUT      = boot_map;
  assign CLK_DOUBLE_OUT    = clk_double;

endmodule

`default_nettype wire

// [tb/rpm_sva.sv]
// checker: port assertions for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpm_sva
  import rpm_pkg::*;
(
  input wire logic        CLK_IN,             // clock
  input wire logic        RST_B_IN,           // reset, low
  input wire logic        PSEL_IN,            // apb select
  input wire logic        PENABLE_IN,         // apb access
  input wire logic        PWRITE_IN,          // apb write
  input wire logic [7:0]  PADDR_IN,           // apb address
  input wire logic [31:0] PWDATA_IN,          // apb data
  input wire logic        RESET_PIN_IN,       // pin level
  input wire logic        RESET_PIN_OE_B_OUT, // pin drive, low
  input wire logic        WD_EXPIRE_IN,       // supervisor expiry
  input wire logic        INT_PENDING_IN,     // idle wake
  input wire logic        EXT_INT_LEVEL_IN,   // level line
  input wire logic        CPU_RESET_OUT,      // internal reset
  input wire logic        CPU_CLK_EN_OUT,     // cpu clock
  input wire logic        PERIPH_CLK_EN_OUT,  // peripheral clock
  input wire logic        OSC_RUN_OUT,        // oscillator
  input wire logic        RAM_BLOCK_OUT       // ram blocked
);
  // ------
  // helpers
  // ------
  logic [7:0] oe_low; // cycles of the current pin drive
  logic [5:0] pin_hi; // high samples since the last pin rise
  logic       pin_q;  // pin one cycle back
  logic       cfg_wr; // write to the power config word
  assign cfg_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & ~CPU_RESET_OUT & ~RESET_PIN_IN
                  & (PADDR_IN == ADDR_POWER_CONFIG);
  // run length is frozen after the pin falls, since reset lags the pin by the sync
  always_ff @(posedge CLK_IN)
  begin
    pin_q  <= RESET_PIN_IN;
    oe_low <= (!RST_B_IN || RESET_PIN_OE_B_OUT) ? 8'h00 : oe_low + 8'h01;
    if (!RST_B_IN)
      pin_hi <= 6'h00;
    else if (RESET_PIN_IN && !pin_q)
      pin_hi <= 6'h01;
    else if (RESET_PIN_IN && pin_hi != 6'h3f)
      pin_hi <= pin_hi + 6'h01;
  end
  // ------
  // assertions
  // ------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wd_start_a: assert property (WD_EXPIRE_IN |=> !RESET_PIN_OE_B_OUT)
    else $error("pin pulse did not start");
  wd_len_a: assert property ($rose(RESET_PIN_OE_B_OUT) |-> oe_low == 8'h60)
    else $error("pin pulse length wrong");
  pd_clock_a: assert property (!OSC_RUN_OUT |-> !PERIPH_CLK_EN_OUT && !CPU_CLK_EN_OUT)
    else $error("clock running in power-down");
  pin_wake_a: assert property (RESET_PIN_IN |-> CPU_CLK_EN_OUT && OSC_RUN_OUT)
    else $error("pin did not restore clocks");
  idle_enter_a: assert property (cfg_wr && PWDATA_IN[POS_IDLE] && !PWDATA_IN[POS_PDOWN]
    && CPU_CLK_EN_OUT |=> RESET_PIN_IN || (!CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT))
    else $error("idle not entered");
  pd_enter_a: assert property (cfg_wr && PWDATA_IN[POS_PDOWN] && CPU_CLK_EN_OUT
    |=> RESET_PIN_IN || !OSC_RUN_OUT)
    else $error("power-down not entered");
  idle_wake_a: assert property (!CPU_CLK_EN_OUT && OSC_RUN_OUT && INT_PENDING_IN
    && !EXT_INT_LEVEL_IN && !CPU_RESET_OUT |=> CPU_CLK_EN_OUT)
    else $error("interrupt did not end idle");
  hold_level_a: assert property ($rose(OSC_RUN_OUT) && $past(EXT_INT_LEVEL_IN)
    |-> RESET_PIN_IN || !CPU_CLK_EN_OUT)
    else $error("resumed with line asserted");
  qual_min_a: assert property ($rose(CPU_RESET_OUT) |-> pin_hi >= 6'h18)
    else $error("reset from a short pulse");
  qual_late_a: assert property (pin_hi == 6'h1c && RESET_PIN_IN |-> CPU_RESET_OUT)
    else $error("qualified pulse gave no reset");
  ram_clear_a: assert property ($rose(CPU_RESET_OUT) |-> ##2 !RAM_BLOCK_OUT)
    else $error("ram block not cleared");
  cover property (!OSC_RUN_OUT);
  cover property ($rose(CPU_RESET_OUT));
  cover property ($rose(RESET_PIN_OE_B_OUT));
endmodule
`default_nettype wire

// [tb/rpm_rst_src.sv]
// partner model: external reset source and pull-down on the reset pin
`timescale 1ns/1ps
`default_nettype none
module rpm_rst_src
(
  input  wire logic       clk_in,  // oscillator clock
  input  wire logic       go_in,   // start a pulse
  input  wire logic [7:0] len_in,  // pulse length in periods
  input  wire logic       oe_b_in, // device drive enable, low
  input  wire logic       drv_in,  // device drive value
  output logic            pin_out  // resolved pin level
);
  // ------
  // pulse source
  // ------
  logic [7:0] left = 8'h00; // periods still to hold
  // the whole asked length is held unless a new go_in reloads the count
  always_ff @(posedge clk_in)
  begin
    if (go_in)
      left <= len_in;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  // pull-down: the pin falls once nobody drives it
  assign pin_out = (left != 8'h00) | (~oe_b_in & drv_in);
endmodule
`default_nettype wire

// [tb/rpm_ctrl_test.sv]
// testbench: top of the power mode controller bench
`timescale 1ns/1ps
`default_nettype none
module rpm_ctrl_test
  import rpm_pkg::*;
;
  // ------
  // signals
  // ------
  logic        clk, rst_b, psel, pen, pwr, pready, pslverr, pin, drv, oe_b, wd, fuse;
  logic        intp, exti, extl, adc, cpu_rst, cpu_clk, per_clk, osc, ram_blk, boot, x2;
  logic        go, er;
  logic [7:0]  paddr, len;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, checks, cyc, fl, lows;

  rpm_ctrl dut (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RESET_PIN_IN(pin), .RESET_PIN_OUT(drv),
    .RESET_PIN_OE_B_OUT(oe_b), .WD_EXPIRE_IN(wd), .BOOT_FUSE_IN(fuse), .INT_PENDING_IN(intp),
    .EXT_INT_IN(exti), .EXT_INT_LEVEL_IN(extl), .ADC_DONE_IN(adc), .CPU_RESET_OUT(cpu_rst),
    .CPU_CLK_EN_OUT(cpu_clk), .PERIPH_CLK_EN_OUT(per_clk), .OSC_RUN_OUT(osc),
    .RAM_BLOCK_OUT(ram_blk), .BOOT_MAP_OUT(boot), .CLK_DOUBLE_OUT(x2));
  rpm_rst_src u_src (.clk_in(clk), .go_in(go), .len_in(len), .oe_b_in(oe_b), .drv_in(drv),
    .pin_out(pin));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard; also counts cycles the device drives the pin
  always @(posedge clk)
  begin
    cyc++;
    if (oe_b === 1'b0)
      lows++;
    if (cyc == 4000)
    begin
      err_total++;
      stop_test();
    end
  end
  // ------
  // tasks
  // ------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] n);
    @(posedge clk);
    go <= 1'b1;
    len <= n;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  initial
  begin
    {psel, pen, pwr, wd, fuse, intp, exti, extl, adc, go} = '0;
    rst_b = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    len = 8'h00;
    fl = $urandom(32'h602cb980);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // status is read-only; the fourth word is unmapped
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("read", rd, (i == 2) ? 32'h6 : RESET_VALUE);
      chk("error", 32'(er), 32'(i == 3));
    end
    // idle with random flags; converter done alone must not wake it
    fl = $urandom & 32'hc;
    apb(1'b1, ADDR_POWER_CONFIG, 32'(fl) | 32'h1);
    tick(2);
    chk("cpu clock", cpu_clk, 1'b0);
    chk("periph clock", per_clk, 1'b1);
    @(posedge clk);
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    tick(1);
    chk("cpu clock", cpu_clk, 1'b0);
    @(posedge clk);
    intp <= 1'b1;
    tick(1);
    chk("cpu clock", cpu_clk, 1'b1);
    @(posedge clk);
    intp <= 1'b0;
    apb(1'b0, ADDR_POWER_CONFIG, 32'h0);
    chk("flags", rd, 32'(fl));
    // idle through the converter option
    apb(1'b1, ADDR_POWER_CONFIG, 32'(fl) | 32'h11);
    tick(1);
    chk("cpu clock", cpu_clk, 1'b0);
    @(posedge clk);
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    tick(1);
    chk("cpu clock", cpu_clk, 1'b1);
    // both request bits, woken by a level line held high
    apb(1'b1, ADDR_POWER_CONFIG, 32'(fl) | 32'h3);
    tick(1);
    chk("clocks", {osc, per_clk, cpu_clk}, 3'b000);
    @(posedge clk);
    extl <= 1'b1;
    exti <= 1'b1;
    @(posedge clk);
    exti <= 1'b0;
    tick(3);
    chk("clocks", {osc, per_clk, cpu_clk}, 3'b110);
    @(posedge clk);
    extl <= 1'b0;
    tick(4);
    chk("clocks", {osc, per_clk, cpu_clk}, 3'b111);
    apb(1'b0, ADDR_POWER_CONFIG, 32'h0);
    chk("flags", rd, 32'(fl));
    // doubling mode, then a pulse too short to qualify
    apb(1'b1, ADDR_AUX_CONTROL, 32'h2);
    pulse(8'h14);
    tick(40);
    chk("reset", cpu_rst, 1'b0);
    chk("doubling", x2, 1'b1);
    // idle left by a long pin pulse, fuse now set
    @(posedge clk);
    fuse <= 1'b1;
    apb(1'b1, ADDR_POWER_CONFIG, 32'h1);
    pulse(8'h1e);
    chk("cpu clock", cpu_clk, 1'b1);
    tick(1);
    chk("ram block", ram_blk, 1'b1);
    for (int i = 0; i < 60 && cpu_rst !== 1'b1; i++)
      tick(1);
    chk("reset", cpu_rst, 1'b1);
    for (int i = 0; i < 60 && cpu_rst !== 1'b0; i++)
      tick(1);
    chk("ram block", ram_blk, 1'b0);
    chk("boot map", {boot, x2}, 2'b10);
    apb(1'b0, ADDR_POWER_CONFIG, 32'h0);
    chk("config", rd, RESET_VALUE);
    // supervisor expiry drives the pin
    lows = 0;
    @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    tick(150);
    chk("pin drive", 32'(lows), 32'h60);
    stop_test();
  end
endmodule
bind rpm_ctrl rpm_sva u_sva (.*);
`default_nettype wire
